// [hw/fcs_pkg.sv]
// fcs_pkg: constants shared by both ends of the flash command sequencer.
// assumes: a single 25 MHz clock domain, byte-wide data and 20-bit bus addresses.
package fcs_pkg;
  localparam int unsigned ADDR_W          = 20;
  localparam int unsigned DATA_W          = 8;
  localparam logic [19:0] UNLOCK1_ADDR    = 20'h0_4555;
  localparam logic [19:0] UNLOCK2_ADDR    = 20'h0_4AAA;
  localparam logic [7:0]  UNLOCK1_DATA    = 8'hAA;
  localparam logic [7:0]  UNLOCK2_DATA    = 8'h55;
  localparam logic [7:0]  CMD_ERASE       = 8'h80;
  localparam logic [7:0]  CMD_PROGRAM     = 8'hA0;
  localparam logic [7:0]  CMD_SECTOR      = 8'h30;
  localparam logic [7:0]  CMD_CHIP        = 8'h10;
  localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
  localparam logic [3:0]  SEQ_ENABLE      = 4'h3;
  localparam logic [3:0]  SEQ_DISABLE     = 4'hC;
  localparam int unsigned TOGGLE_BIT      = 6;
  localparam int unsigned SECTOR_LSB      = 12;
  localparam int unsigned ARRAY_AW        = 16;
  // times as printed, in microseconds
  localparam int unsigned PROG_TIME_US    = 40;
  localparam int unsigned ERASE_TIME_US   = 30000;
  localparam int unsigned CLK_MHZ         = 25;
  localparam int unsigned PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned ERASE_CYCLES    = ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W           = 20;
  localparam logic [19:0] CNT_ONE         = 20'h0_0001;
  localparam logic [15:0] ADDR_ONE        = 16'h0001;
endpackage : fcs_pkg

// [hw/fcs_if.sv]
// fcs_if: the cpu-side bus between the controlling program and the flash sequencer.
// assumes: one request at a time; a read answer arrives one cycle after the strobe.
`timescale 1ns/10ps
interface fcs_if (
  input wire logic ref_clk
);
  logic                        wr_stb;
  logic                        rd_stb;
  logic [fcs_pkg::ADDR_W-1:0]  addr;
  logic [fcs_pkg::DATA_W-1:0]  wdata;
  logic [fcs_pkg::DATA_W-1:0]  rdata;
  logic                        rvalid;
  logic                        ctl_wr;
  logic [3:0]                  ctl_mode;
  logic                        busy;

  modport dev (
    input  wr_stb, rd_stb, addr, wdata, ctl_wr, ctl_mode,
    output rdata, rvalid, busy
  );
  modport cpu (
    output wr_stb, rd_stb, addr, wdata, ctl_wr, ctl_mode,
    input  rdata, rvalid, busy
  );
endinterface : fcs_if

// [hw/fcs_device.sv]
// fcs_device: flash array with unlock-sequence decoder, program/erase timer and
// toggle-bit polling.
// assumes: the cpu end drives one strobe per cycle at most and runs from ram.
`timescale 1ns/10ps
module fcs_device #(
  parameter int unsigned PROG_CYC  = fcs_pkg::PROG_CYCLES,
  parameter int unsigned ERASE_CYC = fcs_pkg::ERASE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  fcs_if.dev       bus,
  input wire logic loader_mode,
  output logic     wdt_disable,
  output logic     op_busy
);
  typedef enum logic [2:0] {
    FCS_IDLE  = 3'b000,
    FCS_UNL1  = 3'b001,
    FCS_UNL2  = 3'b010,
    FCS_ER3   = 3'b011,
    FCS_ER4   = 3'b100,
    FCS_ER5   = 3'b101,
    FCS_PROG  = 3'b110,
    FCS_BUSY  = 3'b111
  } fcs_state_t;

  typedef enum logic [1:0] {
    FCS_OP_BYTE   = 2'b00,
    FCS_OP_SECTOR = 2'b01,
    FCS_OP_CHIP   = 2'b10
  } fcs_op_t;

  typedef struct packed {
    fcs_state_t                      st;
    fcs_op_t                         op;
    logic [3:0]                      mode;
    logic [fcs_pkg::CNT_W-1:0]       cnt;
    logic [fcs_pkg::ARRAY_AW-1:0]    tgt;
    logic [fcs_pkg::DATA_W-1:0]      tdata;
    logic                            tog;
    logic                            sweep;
    logic [fcs_pkg::DATA_W-1:0]      rdata;
    logic                            rvalid;
    logic                            wdt_dis;
    logic                            busy;
  } fcs_dev_t;

  localparam int unsigned DEPTH = 1 << fcs_pkg::ARRAY_AW;

  fcs_dev_t                     s_r;
  fcs_dev_t                     s_nxt;
  logic [fcs_pkg::DATA_W-1:0]   mem [DEPTH];
  logic                         mem_we;
  logic [fcs_pkg::ARRAY_AW-1:0] mem_wa;
  logic [fcs_pkg::DATA_W-1:0]   mem_wd;
  logic [fcs_pkg::ARRAY_AW-1:0] ra;
  logic                         seq_on;

  assign ra     = bus.addr[fcs_pkg::ARRAY_AW-1:0];
  assign seq_on = (s_r.mode == fcs_pkg::SEQ_ENABLE);

  // sequence decoder, timer and read path in one next-state block
  always_comb begin
    s_nxt        = s_r;
    s_nxt.rvalid = 1'b0;
    mem_we       = 1'b0;
    mem_wa       = s_r.tgt;
    mem_wd       = s_r.tdata;
    if (bus.ctl_wr) begin
      s_nxt.mode = bus.ctl_mode;
    end
    // loader mode has the watchdog held off on behalf of the loaded code
    s_nxt.wdt_dis = loader_mode;
    if (bus.rd_stb) begin
      s_nxt.rvalid = 1'b1;
      if (s_r.st == FCS_BUSY) begin
        // status instead of array data, vector fetches included
        s_nxt.rdata = '0;
        s_nxt.rdata[fcs_pkg::TOGGLE_BIT] = s_r.tog;
        s_nxt.tog = ~s_r.tog;
      end else begin
        s_nxt.rdata = mem[ra];
      end
    end
    unique case (s_r.st)
      FCS_IDLE: begin
        if (bus.wr_stb && seq_on && bus.addr == fcs_pkg::UNLOCK1_ADDR
            && bus.wdata == fcs_pkg::UNLOCK1_DATA) begin
          s_nxt.st = FCS_UNL1;
        end
      end
      FCS_UNL1: begin
        if (bus.wr_stb) begin
          s_nxt.st = (bus.addr == fcs_pkg::UNLOCK2_ADDR
                      && bus.wdata == fcs_pkg::UNLOCK2_DATA) ? FCS_UNL2 : FCS_IDLE;
        end
      end
      FCS_UNL2: begin
        if (bus.wr_stb) begin
          s_nxt.st = FCS_IDLE;
          if (bus.addr == fcs_pkg::UNLOCK1_ADDR) begin
            if (bus.wdata == fcs_pkg::CMD_ERASE) s_nxt.st = FCS_ER3;
            if (bus.wdata == fcs_pkg::CMD_PROGRAM) s_nxt.st = FCS_PROG;
          end
        end
      end
      FCS_ER3: begin
        if (bus.wr_stb) begin
          s_nxt.st = (bus.addr == fcs_pkg::UNLOCK1_ADDR
                      && bus.wdata == fcs_pkg::UNLOCK1_DATA) ? FCS_ER4 : FCS_IDLE;
        end
      end
      FCS_ER4: begin
        if (bus.wr_stb) begin
          s_nxt.st = (bus.addr == fcs_pkg::UNLOCK2_ADDR
                      && bus.wdata == fcs_pkg::UNLOCK2_DATA) ? FCS_ER5 : FCS_IDLE;
        end
      end
      FCS_ER5: begin
        if (bus.wr_stb) begin
          s_nxt.st  = FCS_IDLE;
          s_nxt.tog = 1'b1;
          s_nxt.cnt = '0;
          if (bus.wdata == fcs_pkg::CMD_SECTOR) begin
            s_nxt.st  = FCS_BUSY;
            s_nxt.op  = FCS_OP_SECTOR;
            s_nxt.tgt = {ra[fcs_pkg::ARRAY_AW-1:fcs_pkg::SECTOR_LSB],
                         {fcs_pkg::SECTOR_LSB{1'b0}}};
          end else if (bus.wdata == fcs_pkg::CMD_CHIP
                       && bus.addr == fcs_pkg::UNLOCK1_ADDR) begin
            s_nxt.st  = FCS_BUSY;
            s_nxt.op  = FCS_OP_CHIP;
            s_nxt.tgt = '0;
          end
        end
      end
      FCS_PROG: begin
        if (bus.wr_stb) begin
          // latched now, committed when the program time has elapsed
          s_nxt.st    = FCS_BUSY;
          s_nxt.op    = FCS_OP_BYTE;
          s_nxt.tgt   = ra;
          s_nxt.tdata = bus.wdata;
          s_nxt.tog   = 1'b1;
          s_nxt.cnt   = '0;
        end
      end
      FCS_BUSY: begin
        // erase sweeps one byte per cycle; it ends once both the sweep and the timer have finished
        if (s_r.op != FCS_OP_BYTE && !s_r.sweep) begin
          mem_we = 1'b1;
          mem_wd = fcs_pkg::ERASED_BYTE;
          s_nxt.tgt = s_r.tgt + fcs_pkg::ADDR_ONE;
          if (s_r.op == FCS_OP_SECTOR) begin
            s_nxt.sweep = &s_r.tgt[fcs_pkg::SECTOR_LSB-1:0];
          end else begin
            s_nxt.sweep = &s_r.tgt;
          end
        end
        s_nxt.cnt = s_r.cnt + fcs_pkg::CNT_ONE;
        if (s_r.op == FCS_OP_BYTE) begin
          if (s_r.cnt == fcs_pkg::CNT_W'(PROG_CYC - 1)) begin
            mem_we   = 1'b1;
            s_nxt.st = FCS_IDLE;
          end
        end else if (s_r.cnt >= fcs_pkg::CNT_W'(ERASE_CYC - 1) && s_r.sweep) begin
          s_nxt.st    = FCS_IDLE;
          s_nxt.sweep = 1'b0;
        end
      end
    endcase
    // registered copy of the busy state so both busy outputs leave a flop
    s_nxt.busy = (s_nxt.st == FCS_BUSY);
  end

  // array storage; no reset, contents survive reset like real flash
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r       <= '0;
      s_r.st    <= FCS_IDLE;
      s_r.mode  <= fcs_pkg::SEQ_DISABLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.rdata  = s_r.rdata;
  assign bus.rvalid = s_r.rvalid;
  assign bus.busy   = s_r.busy;
  assign op_busy    = s_r.busy;
  assign wdt_disable = s_r.wdt_dis;
endmodule : fcs_device

// [hw/fcs_cpu.sv]
// fcs_cpu: the ram-resident control program as a small engine: issues program,
// sector and chip erase sequences and polls completion.
// assumes: the device answers reads one cycle after rd_stb.
`timescale 1ns/10ps
module fcs_cpu (
  input wire logic                       ref_clk,
  input wire logic                       rst,
  fcs_if.cpu                             bus,
  input wire logic                       req,
  input wire logic [1:0]                 req_op,
  input wire logic [fcs_pkg::ADDR_W-1:0] req_addr,
  input wire logic [fcs_pkg::DATA_W-1:0] req_data,
  output logic                           done,
  output logic                           imf_clear,
  output logic                           wdt_off
);
  typedef enum logic [2:0] {
    FCC_IDLE = 3'b000,
    FCC_PREP = 3'b001,
    FCC_SEQ  = 3'b010,
    FCC_RD1  = 3'b011,
    FCC_RD2  = 3'b100,
    FCC_CMP  = 3'b101,
    FCC_END  = 3'b110
  } fcc_state_t;

  typedef struct packed {
    fcc_state_t                  st;
    logic [2:0]                  step;
    logic [1:0]                  op;
    logic [fcs_pkg::ADDR_W-1:0]  a;
    logic [fcs_pkg::DATA_W-1:0]  d;
    logic [fcs_pkg::DATA_W-1:0]  first;
    logic                        wr;
    logic                        rd;
    logic [fcs_pkg::ADDR_W-1:0]  addr;
    logic [fcs_pkg::DATA_W-1:0]  wdata;
    logic                        cwr;
    logic [3:0]                  cmode;
    logic                        done;
    logic                        interrupt_master_flag;
    logic                        wdt;
  } fcc_t;

  fcc_t                        s_r;
  fcc_t                        s_nxt;
  logic [fcs_pkg::ADDR_W-1:0]  sa;
  logic [fcs_pkg::DATA_W-1:0]  sd;
  logic [2:0]                  last;

  // cycle table: op 0 program, 1 sector erase, 2 chip erase
  always_comb begin
    sa   = fcs_pkg::UNLOCK1_ADDR;
    sd   = fcs_pkg::UNLOCK1_DATA;
    last = (s_r.op == 2'h0) ? 3'h3 : 3'h5;
    unique case (s_r.step)
      3'h1, 3'h4: begin
        sa = fcs_pkg::UNLOCK2_ADDR;
        sd = fcs_pkg::UNLOCK2_DATA;
      end
      3'h2: sd = (s_r.op == 2'h0) ? fcs_pkg::CMD_PROGRAM : fcs_pkg::CMD_ERASE;
      3'h3: begin
        if (s_r.op == 2'h0) begin
          sa = s_r.a;
          sd = s_r.d;
        end
      end
      3'h5: begin
        sa = (s_r.op == 2'h1) ? s_r.a : fcs_pkg::UNLOCK1_ADDR;
        sd = (s_r.op == 2'h1) ? fcs_pkg::CMD_SECTOR : fcs_pkg::CMD_CHIP;
      end
      default: ;
    endcase
  end

  // control program sequencing
  always_comb begin
    s_nxt      = s_r;
    s_nxt.wr   = 1'b0;
    s_nxt.rd   = 1'b0;
    s_nxt.cwr  = 1'b0;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      FCC_IDLE: begin
        if (req) begin
          s_nxt.op  = req_op;
          s_nxt.a   = req_addr;
          s_nxt.d   = req_data;
          s_nxt.interrupt_master_flag = 1'b1;
          s_nxt.wdt = 1'b1;
          s_nxt.st  = FCC_PREP;
        end
      end
      FCC_PREP: begin
        s_nxt.cwr   = 1'b1;
        s_nxt.cmode = fcs_pkg::SEQ_ENABLE;
        s_nxt.step  = '0;
        s_nxt.st    = FCC_SEQ;
      end
      FCC_SEQ: begin
        s_nxt.wr    = 1'b1;
        s_nxt.addr  = sa;
        s_nxt.wdata = sd;
        s_nxt.step  = s_r.step + 3'h1;
        if (s_r.step == last) s_nxt.st = FCC_RD1;
      end
      FCC_RD1: begin
        s_nxt.rd   = 1'b1;
        s_nxt.addr = s_r.a;
        s_nxt.st   = FCC_RD2;
      end
      FCC_RD2: begin
        if (bus.rvalid) begin
          s_nxt.first = bus.rdata;
          s_nxt.rd    = 1'b1;
          s_nxt.st    = FCC_CMP;
        end
      end
      FCC_CMP: begin
        if (bus.rvalid) begin
          s_nxt.st = (bus.rdata == s_r.first) ? FCC_END : FCC_RD1;
        end
      end
      FCC_END: begin
        s_nxt.cwr   = 1'b1;
        s_nxt.cmode = fcs_pkg::SEQ_DISABLE;
        s_nxt.done  = 1'b1;
        s_nxt.st    = FCC_IDLE;
      end
      default: s_nxt.st = FCC_IDLE;
    endcase
  end

  // state register; erasing before reprogramming is the requester's duty
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r       <= '0;
      s_r.st    <= FCC_IDLE;
      s_r.cmode <= fcs_pkg::SEQ_DISABLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.wr_stb   = s_r.wr;
  assign bus.rd_stb   = s_r.rd;
  assign bus.addr     = s_r.addr;
  assign bus.wdata    = s_r.wdata;
  assign bus.ctl_wr   = s_r.cwr;
  assign bus.ctl_mode = s_r.cmode;
  assign done         = s_r.done;
  assign imf_clear    = s_r.interrupt_master_flag;
  assign wdt_off      = s_r.wdt;
endmodule : fcs_cpu

// [verification/fcs_checker.sv]
// fcs_checker: bus-level assertions beside the cpu-to-device interface.
// assumes: plain copies of the interface signals, one clock, sync high reset.
`timescale 1ns/10ps
module fcs_checker #(
  parameter int unsigned BUSY_MAX = 70000
) (
  input wire logic                       ref_clk,
  input wire logic                       rst,
  input wire logic                       wr_stb,
  input wire logic                       rd_stb,
  input wire logic [fcs_pkg::ADDR_W-1:0] addr,
  input wire logic [fcs_pkg::DATA_W-1:0] wdata,
  input wire logic [fcs_pkg::DATA_W-1:0] rdata,
  input wire logic                       rvalid,
  input wire logic                       ctl_wr,
  input wire logic [3:0]                 ctl_mode,
  input wire logic                       busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic [3:0]  mode_r;
  logic [16:0] cnt_r;

  // mirror of the enable field and busy length; counter avoids long repetitions
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_r <= fcs_pkg::SEQ_DISABLE;
      cnt_r  <= '0;
    end else begin
      if (ctl_wr) begin
        mode_r <= ctl_mode;
      end
      cnt_r <= busy ? cnt_r + 17'h0_0001 : '0;
    end
  end

  // two polling reads one idle cycle apart, the spacing the cpu end uses
  sequence s_two_busy_reads;
    (rd_stb && busy) ##1 (!rd_stb && busy) ##1 (rd_stb && busy);
  endsequence

  rvalid_follows_a: assert property (rd_stb |=> rvalid)
    else $error("read strobe not answered next cycle");
  rvalid_cause_a: assert property (rvalid |-> $past(rd_stb))
    else $error("read answer without a read");
  rdata_hold_a: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved without an answer");
  busy_masked_a: assert property (rd_stb && busy |=> rvalid && (rdata & 8'hBF) == 8'h00)
    else $error("array data leaked while busy");
  toggle_flip_a: assert property (s_two_busy_reads |=> rdata[6] != $past(rdata[6], 2))
    else $error("toggle bit did not invert");
  busy_after_write_a: assert property ($rose(busy) |-> $past(wr_stb))
    else $error("busy rose without a final write");
  busy_enabled_a: assert property ($rose(busy) |-> mode_r == fcs_pkg::SEQ_ENABLE)
    else $error("operation started while locked");
  busy_min_a: assert property ($rose(busy) |-> busy [*8])
    else $error("operation ended too soon");
  busy_gap_a: assert property ($fell(busy) |-> !busy [*4])
    else $error("operation restarted without a sequence");
  busy_max_a: assert property (cnt_r < BUSY_MAX)
    else $error("operation never ended");
endmodule : fcs_checker

// [verification/testbench.sv]
// testbench: cpu engine against one device, plus a second device driven here.
// assumes: reduced program and erase timing parameters; 25 MHz clock.
`timescale 1ns/10ps
module testbench;
  logic        ref_clk;
  logic        rst;
  logic        loader_mode;
  logic        req;
  logic [1:0]  req_op;
  logic [19:0] req_addr;
  logic [7:0]  req_data;
  logic        done;
  logic        imf_clear;
  logic        wdt_off;
  logic        wdt_disable;
  logic        op_busy;
  logic [7:0]  r1;
  logic [7:0]  r2;
  int          num_errors;
  int          checks;

  fcs_if bus_a (.ref_clk(ref_clk));
  fcs_if bus_b (.ref_clk(ref_clk));

  fcs_device #(.PROG_CYC(20), .ERASE_CYC(100)) fcs_device_inst (.ref_clk(ref_clk),
    .rst(rst), .bus(bus_a), .loader_mode(loader_mode), .wdt_disable(wdt_disable),
    .op_busy(op_busy));
  fcs_device #(.PROG_CYC(20), .ERASE_CYC(100)) fcs_device_inst_b (.ref_clk(ref_clk),
    .rst(rst), .bus(bus_b), .loader_mode(1'h0), .wdt_disable(), .op_busy());
  fcs_cpu fcs_cpu_inst (.ref_clk(ref_clk), .rst(rst), .bus(bus_a), .req(req),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .done(done),
    .imf_clear(imf_clear), .wdt_off(wdt_off));
  fcs_checker fcs_checker_inst (.ref_clk(ref_clk), .rst(rst), .wr_stb(bus_a.wr_stb),
    .rd_stb(bus_a.rd_stb), .addr(bus_a.addr), .wdata(bus_a.wdata), .rdata(bus_a.rdata),
    .rvalid(bus_a.rvalid), .ctl_wr(bus_a.ctl_wr), .ctl_mode(bus_a.ctl_mode),
    .busy(bus_a.busy));

  // 40 ns clock
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  task close_out;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: data %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk1

  // one-cycle write strobe on the second device, issued from outside the array
  task wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_b.wr_stb <= 1'h1;
    bus_b.addr   <= a;
    bus_b.wdata  <= d;
    @(posedge ref_clk);
    bus_b.wr_stb <= 1'h0;
  endtask : wr

  // two reads back to back; answers come one cycle after each strobe
  task rd2(input logic [19:0] a);
    @(posedge ref_clk);
    bus_b.rd_stb <= 1'h1;
    bus_b.addr   <= a;
    @(posedge ref_clk);
    #1 r1 = bus_b.rdata;
    @(posedge ref_clk);
    bus_b.rd_stb <= 1'h0;
    #1 r2 = bus_b.rdata;
  endtask : rd2

  task ctl(input logic [3:0] m);
    @(posedge ref_clk);
    bus_b.ctl_wr   <= 1'h1;
    bus_b.ctl_mode <= m;
    @(posedge ref_clk);
    bus_b.ctl_wr   <= 1'h0;
  endtask : ctl

  task cmd(input logic [7:0] c, input logic [19:0] a, input logic [7:0] d);
    wr(fcs_pkg::UNLOCK1_ADDR, fcs_pkg::UNLOCK1_DATA);
    wr(fcs_pkg::UNLOCK2_ADDR, fcs_pkg::UNLOCK2_DATA);
    wr(fcs_pkg::UNLOCK1_ADDR, c);
    if (c == fcs_pkg::CMD_ERASE) begin
      wr(fcs_pkg::UNLOCK1_ADDR, fcs_pkg::UNLOCK1_DATA);
      wr(fcs_pkg::UNLOCK2_ADDR, fcs_pkg::UNLOCK2_DATA);
    end
    wr(a, d);
  endtask : cmd

  // busy one cycle after the last write, toggle starts at one
  task busy_start(input logic [19:0] a);
    @(posedge ref_clk);
    #1 chk1(1'h1, bus_b.busy);
    rd2(a);
    chk8(8'h40, r1);
    chk8(8'h00, r2);
  endtask : busy_start

  // poll until two reads agree; bounded so a stuck device still ends
  task poll(input logic [19:0] a);
    int n;
    n = 0;
    do begin
      rd2(a);
      n++;
    end while (r1 !== r2 && n < 30000);
    // a device that never settles counts as a mismatch
    if (n >= 30000) begin
      num_errors++;
      $display("ERROR %0t: polling limit reached", $time);
    end
  endtask : poll

  // broken sequence followed by a stray write must leave the array alone
  task junk(input logic [19:0] a0, input logic [7:0] d0, input logic [19:0] a1,
            input logic [7:0] d1, input logic [7:0] c);
    wr(a0, d0);
    wr(a1, d1);
    wr(fcs_pkg::UNLOCK1_ADDR, c);
    wr(20'h0_E001, 8'h11);
    @(posedge ref_clk);
    #1 chk1(1'h0, bus_b.busy);
    rd2(20'h0_E001);
    chk8(fcs_pkg::ERASED_BYTE, r1);
  endtask : junk

  task op(input logic [1:0] o, input logic [19:0] a, input logic [7:0] d);
    int   n;
    logic seen;
    @(posedge ref_clk);
    req      <= 1'h1;
    req_op   <= o;
    req_addr <= a;
    req_data <= d;
    @(posedge ref_clk);
    req <= 1'h0;
    n = 0;
    seen = 1'h0;
    do begin
      @(posedge ref_clk);
      #1 n++;
      seen = seen | op_busy;
    end while (done !== 1'h1 && n < 70000);
    chk1(1'h1, done);
    chk1(1'h1, seen);
    chk1(1'h0, op_busy);
  endtask : op

  task run_a;
    loader_mode <= 1'h1;
    #1 chk1(1'h0, wdt_disable);
    chk1(1'h0, imf_clear);
    repeat (2) @(posedge ref_clk);
    #1 chk1(1'h1, wdt_disable);
    for (int i = 0; i < 3; i++) begin
      op(i[1:0], 20'h0_E010, 8'h3C);
    end
    chk1(1'h1, imf_clear);
    chk1(1'h1, wdt_off);
    $display("cpu engine test finished");
  endtask : run_a

  task run_b;
    cmd(fcs_pkg::CMD_PROGRAM, 20'h0_5000, 8'h12);
    @(posedge ref_clk);
    #1 chk1(1'h0, bus_b.busy);
    ctl(fcs_pkg::SEQ_ENABLE);
    cmd(fcs_pkg::CMD_ERASE, fcs_pkg::UNLOCK1_ADDR, fcs_pkg::CMD_CHIP);
    busy_start(20'h0_5000);
    poll(20'h0_5000);
    chk8(fcs_pkg::ERASED_BYTE, r2);
    cmd(fcs_pkg::CMD_PROGRAM, 20'h0_E000, 8'h3F);
    busy_start(20'h0_E000);
    poll(20'h0_E000);
    chk8(8'h3F, r2);
    cmd(fcs_pkg::CMD_PROGRAM, 20'h0_F000, 8'h5A);
    busy_start(20'h0_F000);
    poll(20'h0_F000);
    chk8(8'h5A, r2);
    junk(fcs_pkg::UNLOCK1_ADDR, 8'hAA, fcs_pkg::UNLOCK2_ADDR, 8'h55, 8'h77);
    junk(fcs_pkg::UNLOCK2_ADDR, 8'hAA, fcs_pkg::UNLOCK1_ADDR, 8'h55, 8'hA0);
    junk(fcs_pkg::UNLOCK1_ADDR, 8'hAA, fcs_pkg::UNLOCK2_ADDR, 8'h55, 8'h80);
    // chip code away from the unlock address is a mismatch
    cmd(fcs_pkg::CMD_ERASE, 20'h0_E001, fcs_pkg::CMD_CHIP);
    @(posedge ref_clk);
    #1 chk1(1'h0, bus_b.busy);
    cmd(fcs_pkg::CMD_ERASE, 20'h0_E800, fcs_pkg::CMD_SECTOR);
    busy_start(20'h0_E000);
    poll(20'h0_E000);
    chk8(fcs_pkg::ERASED_BYTE, r2);
    rd2(20'h0_F000);
    chk8(8'h5A, r1);
    ctl(fcs_pkg::SEQ_DISABLE);
    cmd(fcs_pkg::CMD_PROGRAM, 20'h0_E000, 8'h00);
    @(posedge ref_clk);
    #1 chk1(1'h0, bus_b.busy);
    rd2(20'h0_E000);
    chk8(fcs_pkg::ERASED_BYTE, r1);
    $display("direct bus test finished");
  endtask : run_b

  // both pairs run side by side to keep the long erases overlapped
  initial begin
    rst            = 1'h1;
    loader_mode    = 1'h0;
    req            = 1'h0;
    req_op         = 2'h0;
    req_addr       = 20'h0_0000;
    req_data       = 8'h00;
    bus_b.wr_stb   = 1'h0;
    bus_b.rd_stb   = 1'h0;
    bus_b.addr     = 20'h0_0000;
    bus_b.wdata    = 8'h00;
    bus_b.ctl_wr   = 1'h0;
    bus_b.ctl_mode = fcs_pkg::SEQ_DISABLE;
    num_errors     = 0;
    checks         = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    fork
      run_a();
      run_b();
    join
    close_out();
  end

  // a chip erase plus a sector erase take about 70k cycles; allow margin
  initial begin
    repeat (90000) @(posedge ref_clk);
    num_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    close_out();
  end
endmodule : testbench
